// [hdl/mprr_pkg.sv]
// Constants and carrier types for the readout mode controller.
// Assumes one memory clock domain shared with the controller pins.
package mprr_pkg;
    localparam int ADDR_W = 14;
    localparam int DQ_W = 16;
    localparam int LAT_W = 6;
    localparam int LAT_DEPTH = 40;

    // Mode register select codes from {BA2,BA1,BA0}
    localparam logic [2:0] BASE_MR_SEL = 3'h0;
    localparam logic [2:0] MR1_SEL = 3'h1;
    localparam logic [2:0] REFR_MR_SEL = 3'h2;
    localparam logic [2:0] RDOUT_MR_SEL = 3'h3;

    // Field positions within the address word
    localparam int RDOUT_LOC_LO = 0;
    localparam int RDOUT_EN_BIT = 2;
    localparam int REFR_RTTWR_LO = 9;
    localparam int MR1_AL_LO = 3;
    localparam int MR1_WL_BIT = 7;
    localparam int BASE_BL_LO = 0;
    localparam int BASE_CL_LO = 4;
    localparam int BASE_CLX_BIT = 2;
    localparam int COL_NIB_BIT = 2;
    localparam int COL_AP_BIT = 10;
    localparam int COL_BC_BIT = 12;

    // Values after reset
    localparam logic [13:0] BASE_RST = 14'h0000;
    localparam logic [13:0] MR1_RST = 14'h0000;
    localparam logic [1:0] RTTWR_RST = 2'h0;
    localparam logic [1:0] LOC_RST = 2'h0;

    // Burst length field codes
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;

    localparam logic [1:0] LOC_CAL = 2'h0;
    localparam logic [1:0] RTTWR_OFF = 2'h0;
    // Beat k of the burst takes bit k, or bit k+4 for an upper-nibble chop
    localparam logic [7:0] CAL_PATTERN = 8'hAA;
    localparam logic [7:0] RSV_PATTERN = 8'h00;
    localparam logic [3:0] BEATS8 = 4'h8;
    localparam logic [3:0] BEATS4 = 4'h4;
    localparam logic [2:0] WR_TERM_CYC = 3'h6;
    localparam logic [4:0] CL_BASE = 5'h04;
    localparam logic [4:0] CL_EXT_BASE = 5'h0C;

    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [ADDR_W-1:0] addr;
    } mprr_cmd_t;

    typedef struct packed {
        logic readout;
        logic chop;
        logic upper;
        logic [1:0] loc;
    } mprr_rd_t;

    typedef enum logic [2:0] {
        CMD_NOP, CMD_MRS, CMD_RD, CMD_WR, CMD_OTHER
    } mprr_op_t;

    typedef enum logic [1:0] {TERM_OFF, TERM_NOM, TERM_WR} mprr_term_t;
endpackage : mprr_pkg

// [hdl/mprr_lat_pipe.sv]
// Delay line placing each read descriptor at its read latency.
// Assumes latency is at least one and below DEPTH.
`timescale 1ns/1ps
module mprr_lat_pipe #(
    parameter int DEPTH = mprr_pkg::LAT_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire mprr_pkg::mprr_rd_t in_desc,
    input wire logic [mprr_pkg::LAT_W-1:0] latency,
    output logic out_valid,
    output mprr_pkg::mprr_rd_t out_desc
);
    logic [DEPTH-1:0] vld_r;
    logic [DEPTH-1:0] vld_nxt;
    mprr_pkg::mprr_rd_t desc_r [DEPTH];
    mprr_pkg::mprr_rd_t desc_nxt [DEPTH];

    always_comb begin
        vld_nxt = {vld_r[DEPTH-2:0], in_valid};
        desc_nxt[0] = in_desc;
        for (int i = 1; i < DEPTH; i++) begin
            desc_nxt[i] = desc_r[i-1];
        end
    end

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_stage
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    vld_r[g] <= 1'b0;
                    desc_r[g] <= '0;
                end else begin
                    vld_r[g] <= vld_nxt[g];
                    desc_r[g] <= desc_nxt[g];
                end
            end
        end
    endgenerate

    localparam logic [mprr_pkg::LAT_W-1:0] LAT_ONE = 6'h01;

    // Tap one short so the serializer register lands at latency
    assign out_valid = vld_r[latency-LAT_ONE];
    assign out_desc = desc_r[latency-LAT_ONE];
endmodule : mprr_lat_pipe

// [hdl/mprr_burst_ser.sv]
// Burst serializer: one beat per clock onto the data pins.
// Assumes array data is already aligned when a normal read plays.
`timescale 1ns/1ps
module mprr_burst_ser #(
    parameter bit REPLICATE = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic start,
    input wire mprr_pkg::mprr_rd_t desc,
    input wire logic [mprr_pkg::DQ_W-1:0] array_dq,
    output logic [mprr_pkg::DQ_W-1:0] dq_r,
    output logic dq_oe_r
);
    mprr_pkg::mprr_rd_t cur_r, cur_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [3:0] left_r, left_nxt;
    logic [mprr_pkg::DQ_W-1:0] dq_nxt;
    logic oe_nxt;
    logic [7:0] pat;
    logic [2:0] order;
    logic bit_v;

    always_comb begin
        cur_nxt = cur_r;
        cnt_nxt = cnt_r;
        left_nxt = left_r;
        if (start) begin
            cur_nxt = desc;
            cnt_nxt = 4'h0;
            left_nxt = desc.chop ? mprr_pkg::BEATS4 : mprr_pkg::BEATS8;
        end else if (left_r != 4'h0) begin
            cnt_nxt = cnt_r + 4'h1;
        end
        // Reserved locations play zeros in the same order
        pat = (cur_nxt.loc == mprr_pkg::LOC_CAL) ?
            mprr_pkg::CAL_PATTERN : mprr_pkg::RSV_PATTERN;
        // Upper nibble gives order 4..7 for chopped bursts
        order = cur_nxt.chop ? {cur_nxt.upper, cnt_nxt[1:0]}
                             : cnt_nxt[2:0];
        bit_v = pat[order];
        oe_nxt = start || (left_r > 4'h1);
        if (!oe_nxt) begin
            dq_nxt = '0;
        end else if (cur_nxt.readout) begin
            // Same bit in every lane, or only bit 0 per byte
            dq_nxt = REPLICATE ? {mprr_pkg::DQ_W{bit_v}}
                               : {7'h00, bit_v, 7'h00, bit_v};
        end else begin
            dq_nxt = array_dq;
        end
        if (!start && left_r != 4'h0) begin
            left_nxt = left_r - 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cur_r <= '0;
            cnt_r <= 4'h0;
            left_r <= 4'h0;
            dq_r <= '0;
            dq_oe_r <= 1'b0;
        end else begin
            cur_r <= cur_nxt;
            cnt_r <= cnt_nxt;
            left_r <= left_nxt;
            dq_r <= dq_nxt;
            dq_oe_r <= oe_nxt;
        end
    end
endmodule : mprr_burst_ser

// [hdl/mprr_mode_ctrl.sv]
// Mode register decode, readout mode control, read latency and
// write termination selection of the memory device.
// Assumes the command pins are sampled at each rising core_clk edge.
`timescale 1ns/1ps
module mprr_mode_ctrl #(
    parameter bit REPLICATE = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire mprr_pkg::mprr_cmd_t cmd,
    input wire logic odt,
    input wire logic [mprr_pkg::DQ_W-1:0] array_dq,
    output logic [mprr_pkg::DQ_W-1:0] dq_out,
    output logic dq_oe,
    output logic array_rd,
    output logic array_wr,
    output logic array_autopre,
    output mprr_pkg::mprr_term_t term_sel,
    output logic [2:0] rtt_nom_out,
    output logic [1:0] rtt_wr_out,
    output logic readout_en,
    output logic [1:0] readout_loc,
    output logic [mprr_pkg::LAT_W-1:0] read_latency,
    output logic illegal_cmd
);
    // Command decode from the pin levels at the rising edge
    function automatic mprr_pkg::mprr_op_t dec_op(
        input mprr_pkg::mprr_cmd_t c,
        input logic cke_prev
    );
        if (!(cke_prev && c.cke)) begin
            dec_op = mprr_pkg::CMD_OTHER;
        end else if (c.cs_n) begin
            dec_op = mprr_pkg::CMD_NOP;
        end else begin
            case ({c.ras_n, c.cas_n, c.we_n})
                3'h0: dec_op = mprr_pkg::CMD_MRS;
                3'h5: dec_op = mprr_pkg::CMD_RD;
                3'h4: dec_op = mprr_pkg::CMD_WR;
                3'h7: dec_op = mprr_pkg::CMD_NOP;
                default: dec_op = mprr_pkg::CMD_OTHER;
            endcase
        end
    endfunction : dec_op

    function automatic logic [4:0] cas_lat(input logic [13:0] m0);
        logic [4:0] code;
        code = {2'h0, m0[mprr_pkg::BASE_CL_LO +: 3]};
        cas_lat = m0[mprr_pkg::BASE_CLX_BIT] ?
            mprr_pkg::CL_EXT_BASE + code : mprr_pkg::CL_BASE + code;
    endfunction : cas_lat

    // Reset pin from outside the clock domain
    logic rp_meta_r;
    logic rp_sync_r;
    logic cke_prev_r;
    logic [13:0] base_r, base_nxt;
    logic [13:0] mr1_r, mr1_nxt;
    logic [1:0] rttwr_r, rttwr_nxt;
    logic ro_en_r, ro_en_nxt;
    logic [1:0] loc_r, loc_nxt;
    logic [2:0] wr_cnt_r, wr_cnt_nxt;
    logic illegal_r, illegal_nxt;
    logic [mprr_pkg::LAT_W-1:0] rl_r, rl_nxt;

    mprr_pkg::mprr_op_t op;
    logic soft_clr;
    logic rd_go;
    logic chop;
    logic [4:0] cl;
    logic [4:0] al;
    mprr_pkg::mprr_rd_t rd_desc;
    logic pipe_vld;
    mprr_pkg::mprr_rd_t pipe_desc;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rp_meta_r <= 1'b0;
            rp_sync_r <= 1'b0;
            cke_prev_r <= 1'b0;
        end else begin
            rp_meta_r <= reset_pin_n;
            rp_sync_r <= rp_meta_r;
            cke_prev_r <= cmd.cke;
        end
    end

    // Pin reset also clears readout mode at any time
    assign soft_clr = !rp_sync_r;
    assign op = dec_op(cmd, cke_prev_r);

    always_comb begin
        base_nxt = base_r;
        mr1_nxt = mr1_r;
        rttwr_nxt = rttwr_r;
        ro_en_nxt = ro_en_r;
        loc_nxt = loc_r;
        illegal_nxt = 1'b0;
        if (soft_clr) begin
            base_nxt = mprr_pkg::BASE_RST;
            mr1_nxt = mprr_pkg::MR1_RST;
            rttwr_nxt = mprr_pkg::RTTWR_RST;
            ro_en_nxt = 1'b0;
            loc_nxt = mprr_pkg::LOC_RST;
        end else if (op == mprr_pkg::CMD_MRS) begin
            case (cmd.ba)
                mprr_pkg::BASE_MR_SEL: base_nxt = cmd.addr;
                mprr_pkg::MR1_SEL: mr1_nxt = cmd.addr;
                mprr_pkg::REFR_MR_SEL: begin
                    rttwr_nxt = cmd.addr[mprr_pkg::REFR_RTTWR_LO +: 2];
                end
                mprr_pkg::RDOUT_MR_SEL: begin
                    // Upper address bits are not checked
                    ro_en_nxt = cmd.addr[mprr_pkg::RDOUT_EN_BIT];
                    loc_nxt = cmd.addr[mprr_pkg::RDOUT_LOC_LO +: 2];
                end
                default: begin
                    illegal_nxt = ro_en_r;
                end
            endcase
        end else if (ro_en_r && op != mprr_pkg::CMD_RD
                     && op != mprr_pkg::CMD_NOP) begin
            // Besides mode writes to select codes 0-3, only reads and NOPs may follow while readout is enabled
            illegal_nxt = 1'b1;
        end
    end

    // Read latency register follows the mode registers
    always_comb begin
        cl = cas_lat(base_r);
        case (mr1_r[mprr_pkg::MR1_AL_LO +: 2])
            2'h1: al = cl - 5'h01;
            2'h2: al = cl - 5'h02;
            default: al = 5'h00;
        endcase
        rl_nxt = {1'b0, al} + {1'b0, cl};
    end

    // Burst chop choice per read
    always_comb begin
        case (base_r[mprr_pkg::BASE_BL_LO +: 2])
            mprr_pkg::BL_FIXED4: chop = 1'b1;
            mprr_pkg::BL_OTF: chop = !cmd.addr[mprr_pkg::COL_BC_BIT];
            default: chop = 1'b0;
        endcase
    end

    assign rd_go = (op == mprr_pkg::CMD_RD);
    // Bank and other column bits do not reach the descriptor
    always_comb begin
        rd_desc.readout = ro_en_r;
        rd_desc.chop = chop;
        rd_desc.upper = chop && cmd.addr[mprr_pkg::COL_NIB_BIT];
        rd_desc.loc = ro_en_r ? loc_r : mprr_pkg::LOC_CAL;
    end

    // Array sees reads and writes only with readout off
    assign array_rd = rd_go && !ro_en_r;
    assign array_wr = (op == mprr_pkg::CMD_WR) && !ro_en_r;
    // Auto-precharge dropped in readout mode
    assign array_autopre = array_rd && cmd.addr[mprr_pkg::COL_AP_BIT];

    // Write termination window after a write command
    always_comb begin
        wr_cnt_nxt = wr_cnt_r;
        if (array_wr) begin
            wr_cnt_nxt = mprr_pkg::WR_TERM_CYC;
        end else if (wr_cnt_r != 3'h0) begin
            wr_cnt_nxt = wr_cnt_r - 3'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            base_r <= mprr_pkg::BASE_RST;
            mr1_r <= mprr_pkg::MR1_RST;
            rttwr_r <= mprr_pkg::RTTWR_RST;
            ro_en_r <= 1'b0;
            loc_r <= mprr_pkg::LOC_RST;
            wr_cnt_r <= 3'h0;
            illegal_r <= 1'b0;
            rl_r <= '0;
        end else begin
            base_r <= base_nxt;
            mr1_r <= mr1_nxt;
            rttwr_r <= rttwr_nxt;
            ro_en_r <= ro_en_nxt;
            loc_r <= loc_nxt;
            wr_cnt_r <= wr_cnt_nxt;
            illegal_r <= illegal_nxt;
            rl_r <= rl_nxt;
        end
    end

    // Termination choice; reserved write code falls back to nominal
    always_comb begin
        if (!odt) begin
            term_sel = mprr_pkg::TERM_OFF;
        end else if (wr_cnt_r != 3'h0 && !mr1_r[mprr_pkg::MR1_WL_BIT]
                     && rttwr_r != mprr_pkg::RTTWR_OFF
                     && rttwr_r != 2'h3) begin
            term_sel = mprr_pkg::TERM_WR;
        end else begin
            term_sel = mprr_pkg::TERM_NOM;
        end
    end

    assign rtt_nom_out = {mr1_r[9], mr1_r[6], mr1_r[2]};
    assign rtt_wr_out = rttwr_r;
    assign readout_en = ro_en_r;
    assign readout_loc = loc_r;
    assign read_latency = rl_r;
    assign illegal_cmd = illegal_r;

    // Readout and array reads share one latency path
    mprr_lat_pipe #(
        .DEPTH(mprr_pkg::LAT_DEPTH)
    ) u_pipe (
        .core_clk(core_clk),
        .rst(rst || soft_clr),
        .in_valid(rd_go),
        .in_desc(rd_desc),
        .latency(rl_r),
        .out_valid(pipe_vld),
        .out_desc(pipe_desc)
    );

    mprr_burst_ser #(
        .REPLICATE(REPLICATE)
    ) u_ser (
        .core_clk(core_clk),
        .rst(rst || soft_clr),
        .start(pipe_vld),
        .desc(pipe_desc),
        .array_dq(array_dq),
        .dq_r(dq_out),
        .dq_oe_r(dq_oe)
    );
endmodule : mprr_mode_ctrl

// [bench/mprr_mode_chk.sv]
// Pin-level assertions for the readout mode controller.
// Bound to mprr_mode_ctrl; sees only its ports.
`timescale 1ns/1ps
module mprr_mode_chk #(
    parameter bit REPLICATE = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire mprr_pkg::mprr_cmd_t cmd,
    input wire logic odt,
    input wire logic [mprr_pkg::DQ_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic array_rd,
    input wire logic array_wr,
    input wire logic array_autopre,
    input wire mprr_pkg::mprr_term_t term_sel,
    input wire logic [1:0] rtt_wr_out,
    input wire logic readout_en,
    input wire logic [1:0] readout_loc,
    input wire logic [mprr_pkg::LAT_W-1:0] read_latency,
    input wire logic illegal_cmd
);
    logic cke_q_r;
    logic [1:0] up_r;
    logic live, taken, mrs, rd, wr;
    // Commands count only once the reset pin sync has settled
    always_ff @(posedge core_clk) begin
        cke_q_r <= cmd.cke;
        if (rst || !reset_pin_n)
            up_r <= 2'h0;
        else if (up_r != 2'h3)
            up_r <= up_r + 2'h1;
    end
    assign live = (up_r == 2'h3);
    assign taken = live && cmd.cke && cke_q_r && !cmd.cs_n;
    assign mrs = taken && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
    assign rd = taken && cmd.ras_n && !cmd.cas_n && cmd.we_n;
    assign wr = taken && cmd.ras_n && !cmd.cas_n && !cmd.we_n;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_en;
        mrs && cmd.ba == 3'h3 |=> readout_en == $past(cmd.addr[2]);
    endproperty
    a_en: assert property (p_en)
        else $error("readout enable not taken from mode write");
    property p_loc;
        mrs && cmd.ba == 3'h3 && cmd.addr[2]
            |=> readout_loc == $past(cmd.addr[1:0]);
    endproperty
    a_loc: assert property (p_loc)
        else $error("readout location not stored");
    property p_redirect;
        rd && readout_en |-> !array_rd && !array_autopre;
    endproperty
    a_redirect: assert property (p_redirect)
        else $error("readout read reached the array");
    property p_normal;
        rd && !readout_en |-> array_rd && array_autopre == cmd.addr[10];
    endproperty
    a_normal: assert property (p_normal)
        else $error("normal read not forwarded");
    property p_illegal;
        wr && readout_en |-> !array_wr ##1 illegal_cmd;
    endproperty
    a_illegal: assert property (p_illegal)
        else $error("write in readout mode not refused");
    property p_lanes;
        dq_oe && readout_en |-> (REPLICATE ? dq_out == {16{dq_out[0]}}
            : (dq_out & 16'hFEFE) == 16'h0000 && dq_out[8] == dq_out[0]);
    endproperty
    a_lanes: assert property (p_lanes)
        else $error("readout lanes disagree");
    property p_rl;
        rd && readout_en && !dq_oe && read_latency == 6'h04
            |=> !dq_oe [*4] ##1 dq_oe;
    endproperty
    a_rl: assert property (p_rl)
        else $error("readout first beat off latency");
    property p_beats;
        $rose(dq_oe) |-> dq_oe [*4];
    endproperty
    a_beats: assert property (p_beats)
        else $error("burst shorter than four beats");
    property p_rttwr;
        mrs && cmd.ba == 3'h2 |=> rtt_wr_out == $past(cmd.addr[10:9]);
    endproperty
    a_rttwr: assert property (p_rttwr)
        else $error("write termination code not stored");
    property p_off;
        !odt |-> term_sel == mprr_pkg::TERM_OFF;
    endproperty
    a_off: assert property (p_off)
        else $error("termination active with odt low");
    property p_pin;
        !reset_pin_n [*3] |=> !readout_en && !dq_oe;
    endproperty
    a_pin: assert property (p_pin)
        else $error("reset pin did not clear readout");
endmodule : mprr_mode_chk

// [bench/mprr_ctl_model.sv]
// Memory controller model driving the command pins.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
module mprr_ctl_model #(
    parameter int LOCK_CYC = 8
) (
    input wire logic core_clk,
    output mprr_pkg::mprr_cmd_t cmd
);
    logic mode_on = 1'b0;
    initial cmd = {1'b1, 4'hF, 3'h0, 14'h0000};
    // Idle address changes every cycle so stale values never match
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge core_clk);
            cmd <= {1'b1, 4'h7, 3'($urandom), 14'($urandom)};
        end
    endtask : idle
    // Pins {cs_n,ras_n,cas_n,we_n}; cke held high around it
    task automatic send(input logic [3:0] pins, input logic [2:0] ba,
        input logic [13:0] a);
        @(posedge core_clk);
        cmd <= {1'b1, pins, ba, a};
        idle(2);
    endtask : send
    task automatic lock_wait();
        idle(LOCK_CYC);
    endtask : lock_wait
    task automatic mrs(input logic [2:0] ba, input logic [13:0] a);
        logic [13:0] v;
        v = (ba == 3'h3) ? (a & 14'h0007) : a;
        if (ba == 3'h3 && v[2] && !mode_on) begin
            send(4'h2, 3'h0, 14'h0400);
            idle(4);
        end
        if (ba == 3'h3)
            mode_on = v[2];
        send(4'h0, ba, v);
    endtask : mrs
    // Column bits 1:0 zero; A2 high only for chopped bursts
    task automatic rd(input logic nib, input logic full);
        logic [13:0] a;
        a = 14'($urandom) & 14'h2FF8;
        a[2] = nib;
        a[12] = full;
        send(4'h5, 3'($urandom), a);
    endtask : rd
    task automatic wr();
        send(4'h4, 3'($urandom), 14'($urandom) & 14'h2BF8);
    endtask : wr
endmodule : mprr_ctl_model

// [bench/mprr_readout_mode_tb_top.sv]
// Self-checking bench for the readout mode controller.
// Assumes the controller model drives every command pin.
`timescale 1ns/1ps
module mprr_readout_mode_tb_top;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic reset_pin_n = 1'b1;
    logic odt = 1'b0;
    logic [15:0] array_dq = 16'h0000;
    mprr_pkg::mprr_cmd_t cmd;
    mprr_pkg::mprr_term_t term_sel;
    logic [15:0] dq_out;
    logic dq_oe, array_rd, array_wr, array_autopre, readout_en, illegal_cmd;
    logic [2:0] rtt_nom_out;
    logic [1:0] rtt_wr_out, readout_loc;
    logic [5:0] read_latency;
    logic [15:0] exp_q[$];
    int fail_count = 0;
    int checked = 0;
    int ill_n = 0;
    always #5 core_clk = ~core_clk;

    mprr_mode_ctrl #(.REPLICATE(1'b1)) u_dut (.core_clk, .rst,
        .reset_pin_n, .cmd, .odt, .array_dq, .dq_out, .dq_oe, .array_rd,
        .array_wr, .array_autopre, .term_sel, .rtt_nom_out, .rtt_wr_out,
        .readout_en, .readout_loc, .read_latency, .illegal_cmd);
    mprr_ctl_model u_ctl (.core_clk, .cmd);

    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic expect_burst(input int n, input logic [7:0] pat,
        input int first);
        for (int k = 0; k < n; k++)
            exp_q.push_back({16{pat[first+k]}});
    endtask : expect_burst
    task automatic drain(input string what);
        int n = 0;
        while ((exp_q.size() != 0 || dq_oe !== 1'b0) && n < 60) begin
            @(posedge core_clk);
            n++;
        end
        check(what, 16'(exp_q.size()), 16'h0000);
        $display("Test %s done", what);
    endtask : drain
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    // Sampled mid-cycle, clear of the edge that launches each beat
    always @(negedge core_clk) begin
        if (illegal_cmd === 1'b1)
            ill_n++;
        if (dq_oe === 1'b1) begin
            if (exp_q.size() == 0)
                check("spare beat", 16'h0001, 16'h0000);
            else
                check("beat", dq_out, exp_q.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        complete_run();
    end

    initial begin
        logic chop;
        void'($urandom(32'hF856));
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        u_ctl.lock_wait();
        check("readout_en", 16'(readout_en), 16'h0000);
        check("read_latency", 16'(read_latency), 16'h0004);
        check("rtt_wr_out", 16'(rtt_wr_out), 16'h0000);
        array_dq <= 16'($urandom);
        u_ctl.mrs(3'h3, 14'h0003);
        for (int k = 0; k < 8; k++)
            exp_q.push_back(array_dq);
        u_ctl.rd(1'b0, 1'b1);
        drain("normal read");
        for (int loc = 0; loc < 4; loc++) begin
            u_ctl.mrs(3'h3, 14'(loc) | 14'h0004);
            check("readout_loc", 16'(readout_loc), 16'(loc));
            expect_burst(8, loc == 0 ? 8'hAA : 8'h00, 0);
            u_ctl.rd(1'b0, 1'b1);
            drain("location");
        end
        for (int m = 0; m < 3; m++) begin
            u_ctl.mrs(3'h3, 14'h0000);
            u_ctl.mrs(3'h0, 14'(m));
            u_ctl.mrs(3'h3, 14'h0004);
            for (int j = 0; j < 4; j++) begin
                chop = (m == 2) || (m == 1 && j[0] == 1'b0);
                if (chop || j[1] == 1'b0) begin
                    expect_burst(chop ? 4 : 8, 8'hAA, j[1] ? 4 : 0);
                    u_ctl.rd(j[1], j[0]);
                    drain("chop select");
                end
            end
        end
        u_ctl.mrs(3'h3, 14'h0000);
        u_ctl.mrs(3'h0, 14'h0030);
        u_ctl.mrs(3'h1, 14'h0008);
        // Latency register trails the mode write by one cycle
        u_ctl.idle(1);
        check("read_latency", 16'(read_latency), 16'h000D);
        u_ctl.mrs(3'h3, 14'h0004);
        expect_burst(8, 8'hAA, 0);
        u_ctl.rd(1'b0, 1'b1);
        drain("long latency");
        ill_n = 0;
        u_ctl.wr();
        u_ctl.idle(1);
        check("illegal_cmd", 16'(ill_n), 16'h0001);
        reset_pin_n <= 1'b0;
        u_ctl.idle(3);
        reset_pin_n <= 1'b1;
        u_ctl.lock_wait();
        check("readout_en", 16'(readout_en), 16'h0000);
        check("read_latency", 16'(read_latency), 16'h0004);
        $display("Test reset pin done");
        u_ctl.mrs(3'h3, 14'h0000);
        u_ctl.mrs(3'h2, 14'h0200);
        check("rtt_wr_out", 16'(rtt_wr_out), 16'h0001);
        odt <= 1'b1;
        u_ctl.wr();
        check("term_sel", 16'(term_sel), 16'(mprr_pkg::TERM_WR));
        u_ctl.mrs(3'h1, 14'h0284);
        check("rtt_nom_out", 16'(rtt_nom_out), 16'h0005);
        u_ctl.wr();
        check("term_sel", 16'(term_sel), 16'(mprr_pkg::TERM_NOM));
        odt <= 1'b0;
        u_ctl.idle(1);
        check("term_sel", 16'(term_sel), 16'(mprr_pkg::TERM_OFF));
        $display("Test termination done");
        complete_run();
    end
endmodule : mprr_readout_mode_tb_top

bind mprr_mode_ctrl mprr_mode_chk #(.REPLICATE(REPLICATE)) u_chk (
    .core_clk(core_clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .cmd(cmd), .odt(odt), .dq_out(dq_out), .dq_oe(dq_oe),
    .array_rd(array_rd), .array_wr(array_wr),
    .array_autopre(array_autopre), .term_sel(term_sel),
    .rtt_wr_out(rtt_wr_out), .readout_en(readout_en),
    .readout_loc(readout_loc), .read_latency(read_latency),
    .illegal_cmd(illegal_cmd));
